// *** hdl/asr_regs.svh ***
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

// Register pointers
`define ASR_ADDR_CH0_MSB 5'h00
`define ASR_ADDR_CH0_MID 5'h01
`define ASR_ADDR_CH0_LSB 5'h02
`define ASR_ADDR_CH1_MSB 5'h03
`define ASR_ADDR_CH1_MID 5'h04
`define ASR_ADDR_CH1_LSB 5'h05
`define ASR_ADDR_MOD 5'h06
`define ASR_ADDR_PHASE 5'h07
`define ASR_ADDR_GAIN 5'h08
`define ASR_ADDR_LOOPCTL 5'h09
`define ASR_ADDR_SETUPA 5'h0A
`define ASR_ADDR_SETUPB 5'h0B

// Command byte fields
`define ASR_CMD_DEV_HI 7
`define ASR_CMD_DEV_LO 6
`define ASR_CMD_PTR_HI 5
`define ASR_CMD_PTR_LO 1
`define ASR_CMD_RD 0
`define ASR_DEV_ADDR 2'h0

// Loop and ready control fields
`define ASR_LOOP_SEL_HI 7
`define ASR_LOOP_SEL_LO 6
`define ASR_RDY_SEL_HI 3
`define ASR_RDY_SEL_LO 2
`define ASR_IDLE_DRIVE 0

// Setup register A fields
`define ASR_WIDTH1 7
`define ASR_WIDTH0 6
`define ASR_OSR_HI 5
`define ASR_OSR_LO 4
`define ASR_PRESC_HI 3
`define ASR_PRESC_LO 2

// Setup register B fields
`define ASR_SRST_HI 7
`define ASR_SRST_LO 6
`define ASR_SHDN_HI 5
`define ASR_SHDN_LO 4
`define ASR_EXT_BYPASS 0

// Reset values
`define ASR_RST_MOD 8'h33
`define ASR_RST_PHASE 8'h00
`define ASR_RST_GAIN 8'h00
`define ASR_RST_LOOPCTL 8'h80
`define ASR_RST_SETUPA 8'hF0
`define ASR_RST_SETUPB 8'h00

// Modulator tick divider: clocks per tick at clock_divider_setting code 0
`define ASR_MOD_DIV_BASE 6'h04

`endif

// *** hdl/asr_pkg.sv ***
package asr_pkg;

  typedef enum logic [2:0] {
    ASR_IDLE,
    ASR_CMD,
    ASR_READ,
    ASR_WRITE,
    ASR_SKIP
  } asr_spi_st_e;

  typedef struct packed {
    logic ch;
    logic [23:0] data;
  } asr_conv_word_s;

  typedef struct packed {
    asr_spi_st_e st;
    logic sck_q;
    logic cs_q;
    logic [2:0] bit_cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic rose;
    logic [4:0] addr;
    logic [7:0] modr;
    logic [7:0] phase;
    logic [7:0] gain;
    logic [7:0] loopctl;
    logic [7:0] seta;
    logic [7:0] setb;
    logic [1:0][23:0] hold;
    logic [1:0][23:0] paired;
    logic [1:0][23:0] outd;
    logic [1:0] frozen;
    logic [1:0] rel_pend;
    logic pulse;
    logic restart;
  } asr_top_state_s;

  // Low bits of the phase that fit the current ratio
  function automatic logic [7:0] osr_mask(input logic [1:0] oversampling_ratio);
    osr_mask = 8'((8'h1F << oversampling_ratio) | 8'h1F);
  endfunction

endpackage

// *** hdl/asr_buf2.sv ***
`timescale 1ns/1ps
module asr_buf2 #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } asr_buf_state_s;

  asr_buf_state_s s;
  asr_buf_state_s next_s;
  logic push;
  logic pop;

  assign in_ready = s.cnt != (AW+1)'(DEPTH);
  assign out_valid = s.cnt != '0;
  assign out_data = s.mem[s.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = AW'(s.wp + 1'b1);
    end
    if (pop) begin
      next_s.rp = AW'(s.rp + 1'b1);
    end
    next_s.cnt = (AW+1)'(s.cnt + push - pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // asr_buf2

// *** hdl/asr_rate_gen.sv ***
`timescale 1ns/1ps
`include "asr_regs.svh"
module asr_rate_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] presc,
  input wire logic [1:0] oversampling_ratio,
  input wire logic [7:0] phase,
  input wire logic restart,
  input wire logic [1:0] held,
  output logic tick,
  output logic [1:0] ev
);
  typedef struct packed {
    logic [5:0] div;
    logic [7:0] cnt;
  } asr_rate_state_s;

  asr_rate_state_s s;
  asr_rate_state_s next_s;
  logic [5:0] limit;
  logic [7:0] mask;

  assign limit = 6'((`ASR_MOD_DIV_BASE << presc) - 6'h01);
  assign mask = asr_pkg::osr_mask(oversampling_ratio);
  assign tick = (s.div == 6'h00) & ~restart;
  // Channel 1 is the reference, channel 0 offset by the phase
  assign ev[1] = tick & (s.cnt == 8'h00) & ~held[1];
  assign ev[0] = tick & (s.cnt == (phase & mask)) & ~held[0];

  always_comb begin
    next_s = s;
    next_s.div = (s.div == 6'h00) ? limit : 6'(s.div - 6'h01);
    if (tick) begin
      next_s.cnt = (s.cnt >= mask) ? 8'h00 : 8'(s.cnt + 8'h01);
    end
    if (restart) begin
      next_s.div = limit;
      next_s.cnt = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // asr_rate_gen

// *** hdl/asr_top.sv ***
`timescale 1ns/1ps
`include "asr_regs.svh"
module asr_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  output logic conversion_ready_pulse_n,
  output logic conversion_ready_pulse_oe,
  input wire asr_pkg::asr_conv_word_s conv_word,
  input wire logic conv_valid,
  output logic conv_ready,
  output logic [1:0] conv_soft_reset,
  output logic [1:0] conv_shutdown,
  output logic [7:0] conv_gain,
  output logic conv_restart
);
  localparam int CW = $bits(asr_pkg::asr_conv_word_s);

  asr_pkg::asr_top_state_s s;
  asr_pkg::asr_top_state_s next_s;
  logic sck_rise;
  logic sck_fall;
  logic tick;
  logic [1:0] ev;
  logic [1:0] held;
  logic [1:0] rdy_sel;
  logic [1:0] oversampling_ratio;
  logic [1:0] presc;
  logic [1:0] width;
  logic drain_ready;
  logic buf_valid;
  logic [CW-1:0] buf_data;
  asr_pkg::asr_conv_word_s word;

  // Channel owning a data pointer
  function automatic logic chan_of(input logic [4:0] a);
    chan_of = a > `ASR_ADDR_CH0_LSB;
  endfunction

  function automatic logic is_data(input logic [4:0] a);
    is_data = a <= `ASR_ADDR_CH1_LSB;
  endfunction

  // Last byte of a channel that the host must clock out
  function automatic logic is_last(input logic [4:0] a, input logic [1:0] w);
    logic c;
    c = chan_of(a);
    if (c) begin
      is_last = a == (w[1] ? `ASR_ADDR_CH1_LSB : `ASR_ADDR_CH1_MID);
    end else begin
      is_last = a == (w[0] ? `ASR_ADDR_CH0_LSB : `ASR_ADDR_CH0_MID);
    end
  endfunction

  // Pointer following a read byte
  function automatic logic [4:0] next_addr(input logic [4:0] a, input logic [1:0] sel,
                                           input logic [1:0] w);
    logic [4:0] lo;
    logic [4:0] hi;
    logic [4:0] nxt;
    lo = 5'h00;
    hi = `ASR_ADDR_SETUPB;
    unique case (sel)
      2'h1: begin
        if (a <= `ASR_ADDR_CH0_LSB) begin
          lo = `ASR_ADDR_CH0_MSB;
          hi = `ASR_ADDR_CH0_LSB;
        end else if (a <= `ASR_ADDR_CH1_LSB) begin
          lo = `ASR_ADDR_CH1_MSB;
          hi = `ASR_ADDR_CH1_LSB;
        end else if (a <= `ASR_ADDR_GAIN) begin
          lo = `ASR_ADDR_MOD;
          hi = `ASR_ADDR_GAIN;
        end else begin
          lo = `ASR_ADDR_LOOPCTL;
          hi = `ASR_ADDR_SETUPB;
        end
      end
      2'h2: begin
        if (a <= `ASR_ADDR_CH1_LSB) begin
          lo = `ASR_ADDR_CH0_MSB;
          hi = `ASR_ADDR_CH1_LSB;
        end else begin
          lo = `ASR_ADDR_MOD;
          hi = `ASR_ADDR_SETUPB;
        end
      end
      2'h0, 2'h3: begin
      end
    endcase
    nxt = 5'(a + 5'h01);
    if (nxt == `ASR_ADDR_CH0_LSB && !w[0]) begin
      nxt = `ASR_ADDR_CH1_MSB;
    end else if (nxt == `ASR_ADDR_CH1_LSB && !w[1]) begin
      nxt = `ASR_ADDR_MOD;
    end
    if (nxt > hi) begin
      nxt = lo;
    end
    if (sel == 2'h0 || a > `ASR_ADDR_SETUPB) begin
      nxt = a;
    end
    next_addr = nxt;
  endfunction

  // Lagging channel: positive phase delays channel 0
  function automatic logic lag_ch(input logic [7:0] ph, input logic [1:0] r);
    logic sign;
    sign = ph[3'(3'h4 + {1'b0, r})];
    lag_ch = !((ph & asr_pkg::osr_mask(r)) != 8'h00 && !sign);
  endfunction

  assign sck_rise = sck & ~s.sck_q;
  assign sck_fall = ~sck & s.sck_q;
  assign rdy_sel = s.loopctl[`ASR_RDY_SEL_HI:`ASR_RDY_SEL_LO];
  assign oversampling_ratio = s.seta[`ASR_OSR_HI:`ASR_OSR_LO];
  assign presc = s.seta[`ASR_PRESC_HI:`ASR_PRESC_LO];
  assign width = {s.seta[`ASR_WIDTH1], s.seta[`ASR_WIDTH0]};
  assign held = s.setb[`ASR_SRST_HI:`ASR_SRST_LO] | s.setb[`ASR_SHDN_HI:`ASR_SHDN_LO];
  assign drain_ready = ~|ev;
  assign word = asr_pkg::asr_conv_word_s'(buf_data);

  assign sdo = s.tx[7];
  assign sdo_oe = (s.st == asr_pkg::ASR_READ) & ~cs_n;
  assign conversion_ready_pulse_n = ~s.pulse;
  assign conversion_ready_pulse_oe = s.pulse | s.loopctl[`ASR_IDLE_DRIVE];
  assign conv_soft_reset = s.setb[`ASR_SRST_HI:`ASR_SRST_LO];
  assign conv_shutdown = s.setb[`ASR_SHDN_HI:`ASR_SHDN_LO];
  assign conv_gain = s.gain;
  assign conv_restart = s.restart;

  asr_buf2 #(
    .WIDTH(CW),
    .DEPTH(2)
  ) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(CW'(conv_word)),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(drain_ready)
  );

  asr_rate_gen u_rate (
    .clk(clk),
    .rst_n(rst_n),
    .presc(presc),
    .oversampling_ratio(oversampling_ratio),
    .phase(s.phase),
    .restart(s.restart),
    .held(held),
    .tick(tick),
    .ev(ev)
  );

  always_comb begin
    logic [7:0] byte_in;
    logic [4:0] ld;
    logic do_load;
    logic fire;
    byte_in = {s.rx[6:0], sdi};
    ld = s.addr;
    do_load = 1'b0;
    fire = 1'b0;
    next_s = s;
    next_s.restart = 1'b0;
    next_s.sck_q = sck;
    next_s.cs_q = cs_n;
    if (cs_n) begin
      next_s.st = asr_pkg::ASR_IDLE;
      next_s.bit_cnt = 3'h0;
      next_s.rose = 1'b0;
      next_s.tx = 8'h00;
      next_s.frozen = 2'h0;
      next_s.rel_pend = 2'h0;
    end else if (s.cs_q) begin
      next_s.st = asr_pkg::ASR_CMD;
      next_s.bit_cnt = 3'h0;
      next_s.rose = 1'b0;
    end else begin
      // Shift only after a rising edge, so a leading fall is ignored
      if (sck_fall && s.rose) begin
        next_s.tx = {s.tx[6:0], 1'b0};
        next_s.rose = 1'b0;
      end
      if (sck_rise) begin
        next_s.rx = byte_in;
        next_s.bit_cnt = 3'(s.bit_cnt + 3'h1);
        next_s.rose = 1'b1;
        if (s.bit_cnt == 3'h7) begin
          next_s.rose = 1'b0;
          next_s.frozen = s.frozen & ~s.rel_pend;
          next_s.rel_pend = 2'h0;
          unique case (s.st)
            asr_pkg::ASR_CMD: begin
              ld = byte_in[`ASR_CMD_PTR_HI:`ASR_CMD_PTR_LO];
              next_s.addr = ld;
              if (byte_in[`ASR_CMD_DEV_HI:`ASR_CMD_DEV_LO] != `ASR_DEV_ADDR) begin
                next_s.st = asr_pkg::ASR_SKIP;
              end else if (byte_in[`ASR_CMD_RD]) begin
                next_s.st = asr_pkg::ASR_READ;
                do_load = 1'b1;
              end else begin
                next_s.st = asr_pkg::ASR_WRITE;
              end
            end
            asr_pkg::ASR_READ: begin
              ld = next_addr(s.addr, s.loopctl[`ASR_LOOP_SEL_HI:`ASR_LOOP_SEL_LO],
                             width);
              next_s.addr = ld;
              do_load = 1'b1;
            end
            asr_pkg::ASR_WRITE: begin
              if (s.addr <= `ASR_ADDR_SETUPB) begin
                next_s.addr = (s.addr == `ASR_ADDR_SETUPB) ? 5'h00 : 5'(s.addr + 5'h01);
                unique case (s.addr)
                  `ASR_ADDR_MOD: next_s.modr = byte_in;
                  `ASR_ADDR_PHASE: begin
                    next_s.phase = byte_in;
                    next_s.restart = 1'b1;
                  end
                  `ASR_ADDR_GAIN: next_s.gain = byte_in;
                  `ASR_ADDR_LOOPCTL: next_s.loopctl = byte_in;
                  `ASR_ADDR_SETUPA: begin
                    next_s.seta = byte_in;
                    if (byte_in[`ASR_OSR_HI:`ASR_PRESC_LO] !=
                        s.seta[`ASR_OSR_HI:`ASR_PRESC_LO]) begin
                      next_s.restart = 1'b1;
                    end
                  end
                  `ASR_ADDR_SETUPB: begin
                    next_s.setb = byte_in;
                    if (byte_in[`ASR_EXT_BYPASS] != s.setb[`ASR_EXT_BYPASS]) begin
                      next_s.restart = 1'b1;
                    end
                  end
                  default: begin
                  end
                endcase
              end
            end
            asr_pkg::ASR_IDLE, asr_pkg::ASR_SKIP: begin
            end
          endcase
        end
      end
    end

    if (do_load) begin
      unique case (ld)
        `ASR_ADDR_CH0_MSB: next_s.tx = s.outd[0][23:16];
        `ASR_ADDR_CH0_MID: next_s.tx = s.outd[0][15:8];
        `ASR_ADDR_CH0_LSB: next_s.tx = s.outd[0][7:0];
        `ASR_ADDR_CH1_MSB: next_s.tx = s.outd[1][23:16];
        `ASR_ADDR_CH1_MID: next_s.tx = s.outd[1][15:8];
        `ASR_ADDR_CH1_LSB: next_s.tx = s.outd[1][7:0];
        `ASR_ADDR_MOD: next_s.tx = s.modr;
        `ASR_ADDR_PHASE: next_s.tx = s.phase;
        `ASR_ADDR_GAIN: next_s.tx = s.gain;
        `ASR_ADDR_LOOPCTL: next_s.tx = s.loopctl;
        `ASR_ADDR_SETUPA: next_s.tx = s.seta;
        `ASR_ADDR_SETUPB: next_s.tx = s.setb;
        default: next_s.tx = 8'h00;
      endcase
      if (is_data(ld)) begin
        next_s.frozen[chan_of(ld)] = 1'b1;
        next_s.rel_pend[chan_of(ld)] = is_last(ld, width);
      end
    end

    // First latch stage fed from the buffer
    if (buf_valid && drain_ready) begin
      next_s.hold[word.ch] = word.data;
    end
    unique case (rdy_sel)
      2'h0: begin
        if (ev[lag_ch(s.phase, oversampling_ratio)] && held == 2'h0) begin
          next_s.paired = s.hold;
          fire = 1'b1;
        end
      end
      2'h1: fire = ev[0];
      2'h2: fire = ev[1];
      2'h3: fire = |ev;
    endcase
    if (rdy_sel != 2'h0) begin
      for (int c = 0; c < 2; c++) begin
        if (ev[c]) begin
          next_s.paired[c] = s.hold[c];
        end
      end
    end
    // Pulse lasts until the next modulator tick
    if (fire) begin
      next_s.pulse = 1'b1;
    end else if (tick) begin
      next_s.pulse = 1'b0;
    end
    for (int c = 0; c < 2; c++) begin
      if (!next_s.frozen[c]) begin
        next_s.outd[c] = next_s.paired[c];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= asr_pkg::ASR_IDLE;
      s.cs_q <= 1'b1;
      s.modr <= `ASR_RST_MOD;
      s.phase <= `ASR_RST_PHASE;
      s.gain <= `ASR_RST_GAIN;
      s.loopctl <= `ASR_RST_LOOPCTL;
      s.seta <= `ASR_RST_SETUPA;
      s.setb <= `ASR_RST_SETUPB;
    end else begin
      s <= next_s;
    end
  end
endmodule // asr_top

// *** verif/asr_top_props.sv ***
`timescale 1ns/1ps
module asr_top_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic conversion_ready_pulse_n,
  input wire logic conversion_ready_pulse_oe,
  input wire logic conv_valid,
  input wire logic conv_ready,
  input wire logic [1:0] conv_soft_reset,
  input wire logic [1:0] conv_shutdown,
  input wire logic [7:0] conv_gain,
  input wire logic conv_restart
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Pulse is one tick of four clocks at clock_divider_setting 0
  sequence s_pulse_body;
    !conversion_ready_pulse_n [*4] ##1 conversion_ready_pulse_n;
  endsequence
  sequence s_cmd_quiet;
    !sdo_oe [*8];
  endsequence
  AST_OE_SELECTED: assert property (sdo_oe |-> !cs_n)
    else $error("serial output enabled while deselected");
  AST_OE_ON_RISE: assert property ($rose(sdo_oe) |-> $past(sck) && !$past(sck, 2))
    else $error("serial output enabled away from a rising clock");
  AST_OE_AFTER_CMD: assert property ($fell(cs_n) |-> s_cmd_quiet)
    else $error("serial output enabled during command byte");
  AST_PULSE_WIDTH: assert property ($fell(conversion_ready_pulse_n) |-> s_pulse_body)
    else $error("ready pulse width wrong");
  AST_PULSE_DRIVEN: assert property (!conversion_ready_pulse_n |-> conversion_ready_pulse_oe)
    else $error("ready pulse not driven");
  AST_PULSE_GAP: assert property ($fell(conversion_ready_pulse_n) |=>
    !$fell(conversion_ready_pulse_n) [*7])
    else $error("ready pulses too close");
  AST_RESTART_PULSE: assert property (conv_restart |-> !$past(cs_n) ##1 !conv_restart)
    else $error("restart not a single pulse after a write");
  AST_CFG_BY_WRITE: assert property ($changed({conv_soft_reset, conv_shutdown, conv_gain})
    |-> !$past(cs_n))
    else $error("configuration changed outside a transfer");
  AST_READY_REFUSE: assert property ($fell(conv_ready) |-> $past(conv_valid))
    else $error("buffer refused with nothing offered");
  AST_SDO_ON_EDGE: assert property ((!cs_n && !$past(cs_n) && $changed(sdo)) |->
    ($past(sck, 1) != $past(sck, 2)) || ($past(sck, 2) != $past(sck, 3)) ||
    ($past(sck, 3) != $past(sck, 4)))
    else $error("serial output moved without a clock edge");
endmodule // asr_top_props

// *** verif/asr_spi_host.sv ***
`timescale 1ns/1ps
module asr_spi_host (
  input wire logic clk,
  output logic cs_n,
  output logic sck,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic idle;
  logic oe_seen;
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    sdi = 1'b0;
    oe_seen = 1'b0;
  end
  // Clock parks at its idle level before select falls
  task automatic open_xfer;
    @(posedge clk);
    sck <= idle;
    repeat (2) @(posedge clk);
    cs_n <= 1'b0;
    oe_seen = 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      sdi <= tx[i];
      repeat (4) @(posedge clk);
      // Undriven line reads as the inverse of its last level
      rx[i] = sdo_oe ? sdo : ~sdo;
      oe_seen = oe_seen | sdo_oe;
      sck <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic close_xfer;
    sck <= idle;
    sdi <= ~sdi;
    repeat (3) @(posedge clk);
    cs_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule // asr_spi_host

// *** verif/asr_top_tb.sv ***
`timescale 1ns/1ps
`include "asr_regs.svh"
module asr_top_tb;
  logic clk;
  logic rst_n;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic rdy_n;
  logic rdy_oe;
  asr_pkg::asr_conv_word_s conv_word;
  logic conv_valid;
  logic conv_ready;
  logic [1:0] soft_rst;
  logic [1:0] shdn;
  logic [7:0] gain;
  logic restart;
  int miscompares;
  int checked;
  int restarts;
  int cycles;
  int n;
  int r0;
  logic [7:0] rx;
  logic [7:0] loop_exp [4] = '{8'h00, 8'h40, 8'h12, 8'h10};
  logic [7:0] sel_exp [4] = '{8'h0A, 8'h0A, 8'h0A, 8'h14};
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  asr_top i_dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .conversion_ready_pulse_n(rdy_n), .conversion_ready_pulse_oe(rdy_oe),
    .conv_word(conv_word), .conv_valid(conv_valid), .conv_ready(conv_ready),
    .conv_soft_reset(soft_rst), .conv_shutdown(shdn), .conv_gain(gain), .conv_restart(restart));
  asr_spi_host i_host (.clk(clk), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
  always @(posedge clk) begin
    if (restart === 1'b1) restarts++;
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d[$]);
    i_host.open_xfer();
    i_host.xfer({`ASR_DEV_ADDR, a, 1'b0}, rx);
    foreach (d[i]) i_host.xfer(d[i], rx);
    i_host.close_xfer();
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e[$]);
    i_host.open_xfer();
    i_host.xfer({`ASR_DEV_ADDR, a, 1'b1}, rx);
    foreach (e[i]) begin
      i_host.xfer(8'h00, rx);
      check("read byte", rx, e[i]);
    end
    i_host.close_xfer();
  endtask
  task automatic watch(input int span, output int cnt);
    logic prev;
    prev = rdy_n;
    cnt = 0;
    repeat (span) begin
      @(posedge clk);
      if (prev === 1'b1 && rdy_n === 1'b0) cnt++;
      prev = rdy_n;
    end
  endtask
  task automatic feed(input logic ch, input logic [23:0] d);
    conv_word <= '{ch: ch, data: d};
    conv_valid <= 1'b1;
    @(posedge clk);
    while (conv_ready !== 1'b1) @(posedge clk);
    conv_valid <= 1'b0;
    @(negedge rdy_n);
    @(negedge rdy_n);
    @(posedge clk);
  endtask
  initial begin
    rst_n = 1'b0;
    conv_word = '0;
    conv_valid = 1'b0;
    miscompares = 0;
    checked = 0;
    restarts = 0;
    cycles = 0;
    i_host.idle = 1'b1;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`ASR_ADDR_MOD, '{8'h33, 8'h00, 8'h00, 8'h80, 8'hF0, 8'h00, 8'h33});
    rd(`ASR_ADDR_CH0_MSB, '{8'h00, 8'h00, 8'h00});
    watch(2048, n);
    check("power-up pulses", 8'(n), 8'h02);
    $display("test defaults done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("pin in reset", {6'h00, rdy_oe, rdy_n}, 8'h01);
    i_host.idle = 1'b0;
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    wr(`ASR_ADDR_SETUPB, '{8'hC0});
    check("soft reset", {6'h00, soft_rst}, 8'h03);
    r0 = restarts;
    wr(`ASR_ADDR_PHASE, '{8'h05, 8'h5A, 8'h80, 8'hC0, 8'h00});
    check("gain", gain, 8'h5A);
    check("soft reset", {6'h00, soft_rst}, 8'h00);
    check("restarts", 8'(restarts - r0), 8'h02);
    $display("test configuration done");
    feed(1'b0, 24'hA1B2C3);
    feed(1'b1, 24'hD4E5F6);
    rd(`ASR_ADDR_CH0_MSB, '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hE5, 8'hF6, 8'hA1});
    i_host.open_xfer();
    i_host.xfer({`ASR_DEV_ADDR, `ASR_ADDR_CH0_MSB, 1'b1}, rx);
    i_host.xfer(8'h00, rx);
    check("frozen msb", rx, 8'hA1);
    feed(1'b0, 24'h102030);
    feed(1'b1, 24'h405060);
    foreach (sel_exp[i]) begin
      i_host.xfer(8'h00, rx);
      check("frozen tail", rx, i == 0 ? 8'hB2 : i == 1 ? 8'hC3 : 8'h40 + 8'(16 * (i - 2)));
    end
    i_host.xfer(8'h00, rx);
    check("frozen tail", rx, 8'h60);
    i_host.close_xfer();
    wr(`ASR_ADDR_SETUPA, '{8'h80});
    rd(`ASR_ADDR_CH0_MSB, '{8'h10, 8'h20, 8'h40, 8'h50, 8'h60, 8'h10});
    wr(`ASR_ADDR_SETUPA, '{8'hC0});
    $display("test data latches done");
    i_host.open_xfer();
    i_host.xfer(8'h43, rx);
    i_host.xfer(8'h00, rx);
    i_host.close_xfer();
    check("foreign device output", {7'h00, i_host.oe_seen}, 8'h00);
    rd(5'h1F, '{8'h00, 8'h00});
    wr(`ASR_ADDR_SETUPB, '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h12});
    for (int c = 0; c < 4; c++) begin
      wr(`ASR_ADDR_LOOPCTL, '{{2'(c), 6'h00}});
      rd(`ASR_ADDR_SETUPB, '{8'h00, loop_exp[c]});
    end
    $display("test addressing done");
    for (int s = 0; s < 4; s++) begin
      wr(`ASR_ADDR_LOOPCTL, '{{4'h8, 2'(s), 2'b01}});
      check("idle pin driven", {6'h00, rdy_oe, rdy_n}, 8'h03);
      watch(1280, n);
      check("pulses by select", 8'(n), sel_exp[s]);
    end
    wr(`ASR_ADDR_SETUPB, '{8'h10});
    check("shutdown", {6'h00, shdn}, 8'h01);
    wr(`ASR_ADDR_LOOPCTL, '{8'h80});
    watch(1280, n);
    check("held channel pulses", 8'(n), 8'h00);
    check("idle pin floats", {6'h00, rdy_oe, rdy_n}, 8'h01);
    wr(`ASR_ADDR_LOOPCTL, '{8'h8C});
    watch(1280, n);
    check("awake channel pulses", 8'(n), 8'h0A);
    $display("test ready pin done");
    r0 = restarts;
    wr(`ASR_ADDR_PHASE, '{8'h05});
    check("restart on rewrite", 8'(restarts - r0), 8'h01);
    wr(`ASR_ADDR_SETUPB, '{8'h01});
    check("restart on bypass", 8'(restarts - r0), 8'h02);
    wr(`ASR_ADDR_SETUPA, '{8'hD0});
    check("restart on ratio", 8'(restarts - r0), 8'h03);
    wr(`ASR_ADDR_SETUPA, '{8'hD0});
    check("no restart on same ratio", 8'(restarts - r0), 8'h03);
    $display("test restart done");
    summarize();
  end
endmodule // asr_top_tb
bind asr_top asr_top_props i_props (.clk, .rst_n, .cs_n, .sck, .sdo, .sdo_oe,
  .conversion_ready_pulse_n, .conversion_ready_pulse_oe, .conv_valid, .conv_ready,
  .conv_soft_reset, .conv_shutdown, .conv_gain, .conv_restart);
